/* rtl/ascdc_params.svh */
`ifndef ASCDC_PARAMS_SVH
`define ASCDC_PARAMS_SVH

// ********************************
// register indexes (byte address = index * 4)
// ********************************
`define ASCDC_IDX_MODE 8'h10
`define ASCDC_IDX_SEL_LOW 8'h13
`define ASCDC_IDX_SEL_MID 8'h14
`define ASCDC_IDX_SEL_HIGH 8'h15
`define ASCDC_IDX_STATUS 8'h16
`define ASCDC_IDX_CLR_EN_LOW 8'h18
`define ASCDC_IDX_CLR_EN_HIGH 8'h19
`define ASCDC_IDX_SRC_INPUT 8'h1a
`define ASCDC_IDX_SRC_MISC 8'h1b
`define ASCDC_ADDR(idx) ({idx, 2'b00})

// ********************************
// fields and reset values
// ********************************
`define ASCDC_RST_BYTE 8'h00
`define ASCDC_MODE_BIT 7
`define ASCDC_TEMP_BIT 5
`define ASCDC_SEL_HIGH_W 6
`define ASCDC_SRC_INPUT_W 5
`define ASCDC_SRC_MISC_W 4
`define ASCDC_MISC_EXT 3
`define ASCDC_MISC_THERM 2
`define ASCDC_MISC_LT_HIGH 1
`define ASCDC_MISC_LT_LOW 0
`define ASCDC_STAT_BUSY_BIT 7
`define ASCDC_SLOTS 22
`define ASCDC_TEMP_SLOT 5'h15
`define ASCDC_CHAN_ZERO 5'h00
`define ASCDC_CHAN_ONE 5'h01

`endif

/* rtl/ascdc_pkg.sv */
package ascdc_pkg;
  typedef enum logic [2:0] {
    ASCDC_IDLE = 3'b001,
    ASCDC_START = 3'b010,
    ASCDC_WAIT = 3'b100
  } ascdc_seq_e;
  typedef logic [21:0] ascdc_mask_t;
  typedef logic [4:0] ascdc_chan_t;
endpackage

/* rtl/ascdc_scan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ascdc_scan_if;
  ascdc_pkg::ascdc_mask_t sel_mask; // slots 0..20 inputs, 21 temp sensor
  logic auto_mode; // repeat passes
  logic trigger; // start one pass in direct mode
  logic conv_done; // engine finished current slot
  logic conv_start; // start converting conv_chan
  ascdc_pkg::ascdc_chan_t conv_chan; // slot being converted
  logic busy; // pass in progress
  modport seq (input sel_mask, input auto_mode, input trigger, input conv_done,
    output conv_start, output conv_chan, output busy);
  modport ctl (output sel_mask, output auto_mode, output trigger, output conv_done,
    input conv_start, input conv_chan, input busy);
endinterface
`default_nettype wire

/* rtl/ascdc_scan_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ascdc_params.svh"
module ascdc_scan_seq import ascdc_pkg::*; (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic clk_en, // freezes state when low
  ascdc_scan_if.seq sif // scan control
);
  ascdc_seq_e state_r;
  ascdc_seq_e state_nxt;
  ascdc_chan_t chan_r;
  ascdc_chan_t chan_nxt;

  // lowest selected slot at or above from; bit 5 flags a hit
  function automatic logic [5:0] find_from(input ascdc_mask_t m, input ascdc_chan_t from);
    logic [5:0] res;
    res = 6'h00;
    for (int i = `ASCDC_SLOTS - 1; i >= 0; i--) begin
      if (m[i] && (5'(i) >= from)) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  wire logic [5:0] first_hit = find_from(sif.sel_mask, `ASCDC_CHAN_ZERO);
  wire logic [5:0] next_hit = find_from(sif.sel_mask, chan_r + `ASCDC_CHAN_ONE);
  wire logic go = sif.trigger | sif.auto_mode;

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    unique case (state_r)
      ASCDC_IDLE: begin
        if (go && first_hit[5]) begin
          state_nxt = ASCDC_START;
          chan_nxt = first_hit[4:0];
        end
      end
      ASCDC_START: begin
        state_nxt = ASCDC_WAIT;
      end
      ASCDC_WAIT: begin
        if (sif.conv_done) begin
          if (next_hit[5]) begin
            state_nxt = ASCDC_START;
            chan_nxt = next_hit[4:0];
          end else if (sif.auto_mode && first_hit[5]) begin
            state_nxt = ASCDC_START;
            chan_nxt = first_hit[4:0];
          end else begin
            state_nxt = ASCDC_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ASCDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ASCDC_IDLE;
      chan_r <= `ASCDC_CHAN_ZERO;
    end else if (clk_en) begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
    end
  end

  assign sif.conv_start = (state_r == ASCDC_START);
  assign sif.conv_chan = chan_r;
  assign sif.busy = (state_r != ASCDC_IDLE);

  // ********************************
  // checks
  // ********************************
  start_selected_a: assert property (@(posedge pclk) disable iff (!presetn)
    sif.conv_start |-> sif.sel_mask[sif.conv_chan])
    else $error("conversion started on a deselected slot");
  direct_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == ASCDC_WAIT && sif.conv_done && !next_hit[5] && !sif.auto_mode)
    |=> state_r == ASCDC_IDLE)
    else $error("direct mode did not idle after the pass");
  auto_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == ASCDC_WAIT && sif.conv_done && !next_hit[5] && sif.auto_mode
    && first_hit[5]) |=> (sif.conv_start && sif.conv_chan == $past(first_hit[4:0])))
    else $error("auto mode did not return to the first slot");
endmodule
`default_nettype wire

/* rtl/ascdc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ascdc_params.svh"
module ascdc_regs import ascdc_pkg::*; (
  input wire logic pclk, // 20 MHz clock
  input wire logic presetn, // async reset
  input wire logic clk_en, // freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic scan_trigger, // start a direct-mode pass
  input wire logic conv_done, // engine finished a slot
  output logic conv_start, // start converting conv_chan
  output logic [4:0] conv_chan, // slot 0..20 inputs, 21 temp sensor
  input wire logic [4:0] input_alarm, // alarms of inputs 16..20
  input wire logic ext_alarm_pin, // external alarm input
  input wire logic thermal_alarm, // thermal alarm
  input wire logic local_temp_high_alarm, // local temp high alarm
  input wire logic local_temp_low_alarm, // local temp low alarm
  output logic [15:0] dac_clear // per-output clear state
);
  ascdc_scan_if sif ();

  // ********************************
  // register storage
  // ********************************
  logic [7:0] input_sel_low_r;
  logic [7:0] input_sel_mid_r;
  logic [`ASCDC_SEL_HIGH_W-1:0] input_sel_high_r;
  logic [7:0] clear_en_low_r;
  logic [7:0] clear_en_high_r;
  logic [`ASCDC_SRC_INPUT_W-1:0] src_input_r;
  logic [`ASCDC_SRC_MISC_W-1:0] src_misc_r;
  logic conversion_mode_sel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [15:0] dac_clear_r;
  logic [15:0] dac_clear_nxt;

  // ********************************
  // apb decode
  // ********************************
  wire logic setup_ph = psel & ~penable & ~pready_r;
  wire logic wr_acc = psel & penable & pready_r & pwrite;
  wire logic hit_mode = (paddr == `ASCDC_ADDR(`ASCDC_IDX_MODE));
  wire logic hit_sel_low = (paddr == `ASCDC_ADDR(`ASCDC_IDX_SEL_LOW));
  wire logic hit_sel_mid = (paddr == `ASCDC_ADDR(`ASCDC_IDX_SEL_MID));
  wire logic hit_sel_high = (paddr == `ASCDC_ADDR(`ASCDC_IDX_SEL_HIGH));
  wire logic hit_status = (paddr == `ASCDC_ADDR(`ASCDC_IDX_STATUS));
  wire logic hit_en_low = (paddr == `ASCDC_ADDR(`ASCDC_IDX_CLR_EN_LOW));
  wire logic hit_en_high = (paddr == `ASCDC_ADDR(`ASCDC_IDX_CLR_EN_HIGH));
  wire logic hit_src_in = (paddr == `ASCDC_ADDR(`ASCDC_IDX_SRC_INPUT));
  wire logic hit_src_misc = (paddr == `ASCDC_ADDR(`ASCDC_IDX_SRC_MISC));
  wire logic hit_any = hit_mode | hit_sel_low | hit_sel_mid | hit_sel_high | hit_status
    | hit_en_low | hit_en_high | hit_src_in | hit_src_misc;

  // reserved bits read as zero since they are never stored
  wire logic [7:0] mode_byte = {conversion_mode_sel_r, 7'h00};
  wire logic [7:0] status_byte = {sif.busy, 2'h0, sif.conv_chan};
  wire logic [7:0] rd_byte =
    hit_mode ? mode_byte :
    hit_sel_low ? input_sel_low_r :
    hit_sel_mid ? input_sel_mid_r :
    hit_sel_high ? {2'h0, input_sel_high_r} :
    hit_status ? status_byte :
    hit_en_low ? clear_en_low_r :
    hit_en_high ? clear_en_high_r :
    hit_src_in ? {3'h0, src_input_r} :
    hit_src_misc ? {4'h0, src_misc_r} : `ASCDC_RST_BYTE;

  // ********************************
  // apb handshake: no wait states, answer registered in setup
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pready_r <= setup_ph;
      if (setup_ph) begin
        prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_r <= ~hit_any;
      end else begin
        prdata_r <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  // ********************************
  // register writes
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_sel_low_r <= `ASCDC_RST_BYTE;
      input_sel_mid_r <= `ASCDC_RST_BYTE;
      input_sel_high_r <= '0;
      clear_en_low_r <= `ASCDC_RST_BYTE;
      clear_en_high_r <= `ASCDC_RST_BYTE;
      src_input_r <= '0;
      src_misc_r <= '0;
      conversion_mode_sel_r <= 1'b0;
    end else if (clk_en && wr_acc) begin
      if (hit_sel_low) begin
        input_sel_low_r <= pwdata[7:0];
      end
      if (hit_sel_mid) begin
        input_sel_mid_r <= pwdata[7:0];
      end
      if (hit_sel_high) begin
        input_sel_high_r <= pwdata[`ASCDC_SEL_HIGH_W-1:0];
      end
      if (hit_en_low) begin
        clear_en_low_r <= pwdata[7:0];
      end
      if (hit_en_high) begin
        clear_en_high_r <= pwdata[7:0];
      end
      if (hit_src_in) begin
        src_input_r <= pwdata[`ASCDC_SRC_INPUT_W-1:0];
      end
      if (hit_src_misc) begin
        src_misc_r <= pwdata[`ASCDC_SRC_MISC_W-1:0];
      end
      if (hit_mode) begin
        conversion_mode_sel_r <= pwdata[`ASCDC_MODE_BIT];
      end
    end
  end

  // ********************************
  // scan sequencer
  // ********************************
  assign sif.sel_mask = {input_sel_high_r, input_sel_mid_r, input_sel_low_r};
  assign sif.auto_mode = conversion_mode_sel_r;
  assign sif.trigger = scan_trigger;
  assign sif.conv_done = conv_done;

  ascdc_scan_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .sif(sif)
  );

  // ********************************
  // clear event
  // ********************************
  wire logic [15:0] clear_en = {clear_en_high_r, clear_en_low_r};
  wire logic [3:0] misc_alarms = {ext_alarm_pin, thermal_alarm, local_temp_high_alarm,
    local_temp_low_alarm};
  wire logic clear_event = (|(input_alarm & src_input_r))
    | (|(misc_alarms & src_misc_r));

  // no output-mode input here: clearing is the same in auto and manual
  assign dac_clear_nxt = clear_event ? clear_en : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_clear_r <= 16'h0000;
    end else if (clk_en) begin
      dac_clear_r <= dac_clear_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_start = sif.conv_start;
  assign conv_chan = sif.conv_chan;
  assign dac_clear = dac_clear_r;

  // ********************************
  // checks
  // ********************************
  clear_enabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && clear_event) |=> dac_clear == $past(clear_en))
    else $error("enabled outputs not cleared on clear event");
  clear_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (dac_clear & ~$past(clear_en)) == 16'h0000)
    else $error("disabled output entered clear state");
  source_alone_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && clear_en == 16'h0000) |=> dac_clear == 16'h0000)
    else $error("clear without clear enable");
  no_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !(|(input_alarm & src_input_r)) && !(|(misc_alarms & src_misc_r)))
    |=> dac_clear == 16'h0000)
    else $error("clear state without a selected alarm");
  ext_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ext_alarm_pin && src_misc_r[`ASCDC_MISC_EXT]) |=> dac_clear == $past(clear_en))
    else $error("external alarm pin source did not clear");
  input_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && input_alarm[4] && src_input_r[4]) |=> dac_clear == $past(clear_en))
    else $error("input 20 alarm source did not clear");
  sel_low_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_acc && hit_sel_low) |=> input_sel_low_r == $past(pwdata[7:0]))
    else $error("low input select write lost");
  temp_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_acc && hit_sel_high)
    |=> sif.sel_mask[`ASCDC_TEMP_SLOT] == $past(pwdata[`ASCDC_TEMP_BIT]))
    else $error("temperature select not at bit 5");
  en_high_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_acc && hit_en_high) |=> clear_en[15:8] == $past(pwdata[7:0]))
    else $error("high clear enable write lost");
  reset_zero_a: assert property (@(posedge pclk)
    $rose(presetn) |-> (sif.sel_mask == '0 && clear_en == 16'h0000 && src_input_r == '0
    && src_misc_r == '0 && dac_clear == 16'h0000))
    else $error("fields not zero after reset");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && setup_ph) |=> pready)
    else $error("apb answer not one cycle after setup");
endmodule
`default_nettype wire

/* tb/ascdc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ascdc_params.svh"
module testbench import ascdc_pkg::*;;
  logic pclk, presetn, clk_en, psel, penable, pwrite, scan_trigger, conv_done;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, conv_start;
  logic [4:0] conv_chan;
  logic [15:0] dac_clear;
  logic [8:0] alarms;
  int errors, num_checks;

  ascdc_regs u_ascdc_regs (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_trigger(scan_trigger), .conv_done(conv_done),
    .conv_start(conv_start), .conv_chan(conv_chan), .input_alarm(alarms[4:0]),
    .ext_alarm_pin(alarms[8]), .thermal_alarm(alarms[7]), .local_temp_high_alarm(alarms[6]),
    .local_temp_low_alarm(alarms[5]), .dac_clear(dac_clear));

  // ********************************
  // helpers
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one idle edge after release so back-to-back calls never reassign psel in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= `ASCDC_ADDR(idx);
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, exp_err}, "read error flag");
  endtask

  task automatic wait_start(input logic [4:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_start !== 1'b1 && n < 50);
    chk({31'h0, conv_start}, 32'h1, "conversion start");
    chk({27'h0, conv_chan}, {27'h0, ch}, "scan slot");
  endtask

  task automatic done_pulse();
    @(posedge pclk);
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask

  // ********************************
  // scenarios
  // ********************************
  logic [7:0] idxs[7] = '{`ASCDC_IDX_SEL_LOW, `ASCDC_IDX_SEL_MID, `ASCDC_IDX_SEL_HIGH,
    `ASCDC_IDX_CLR_EN_LOW, `ASCDC_IDX_CLR_EN_HIGH, `ASCDC_IDX_SRC_INPUT, `ASCDC_IDX_SRC_MISC};
  logic [7:0] masks[7] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h1f, 8'h0f};
  logic [4:0] slots[4] = '{5'h00, 5'h03, 5'h14, 5'h15};

  task automatic test_regs();
    for (int i = 0; i < 7; i++) rd_chk(idxs[i], 32'h0, 1'b0);
    rd_chk(8'h17, 32'h0, 1'b1);
    // software keeps reserved bits zero, so only defined fields are written
    for (int i = 0; i < 7; i++) begin
      wr(idxs[i], {24'h0, masks[i]});
      rd_chk(idxs[i], {24'h0, masks[i]}, 1'b0);
      wr(idxs[i], {24'h0, masks[i] & 8'h5a});
      rd_chk(idxs[i], {24'h0, masks[i] & 8'h5a}, 1'b0);
      wr(idxs[i], 32'h0);
    end
    $display("test regs done");
  endtask

  task automatic test_clear();
    wr(`ASCDC_IDX_CLR_EN_LOW, 32'ha5);
    wr(`ASCDC_IDX_CLR_EN_HIGH, 32'h3c);
    for (int i = 0; i < 9; i++) begin
      alarms <= 9'h1 << i;
      repeat (3) @(posedge pclk);
      chk({16'h0, dac_clear}, 32'h0, "clear without source");
      wr(`ASCDC_IDX_SRC_INPUT, (i < 5) ? (32'h1 << i) : 32'h0);
      wr(`ASCDC_IDX_SRC_MISC, (i >= 5) ? (32'h1 << (i - 5)) : 32'h0);
      repeat (3) @(posedge pclk);
      chk({16'h0, dac_clear}, 32'h3ca5, "clear event");
      alarms <= 9'h0;
      repeat (3) @(posedge pclk);
      chk({16'h0, dac_clear}, 32'h0, "clear follows alarm");
    end
    wr(`ASCDC_IDX_CLR_EN_LOW, 32'h0);
    repeat (3) @(posedge pclk);
    $display("test clear done");
  endtask

  task automatic test_direct();
    int cnt;
    wr(`ASCDC_IDX_SEL_LOW, 32'h09);
    wr(`ASCDC_IDX_SEL_HIGH, 32'h30);
    scan_trigger <= 1'b1;
    @(posedge pclk);
    scan_trigger <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wait_start(slots[k]);
      if (k == 0) rd_chk(`ASCDC_IDX_STATUS, 32'h80, 1'b0);
      done_pulse();
    end
    cnt = 0;
    repeat (20) begin
      @(posedge pclk);
      if (conv_start === 1'b1) cnt++;
    end
    chk(cnt, 0, "idle after one pass");
    $display("test direct done");
  endtask

  task automatic test_auto();
    int cnt;
    wr(`ASCDC_IDX_MODE, 32'h80);
    for (int k = 0; k < 4; k++) begin
      wait_start(slots[k]);
      done_pulse();
    end
    wait_start(slots[0]);
    wr(`ASCDC_IDX_MODE, 32'h0);
    done_pulse();
    for (int k = 1; k < 4; k++) begin
      wait_start(slots[k]);
      done_pulse();
    end
    cnt = 0;
    repeat (20) begin
      @(posedge pclk);
      if (conv_start === 1'b1) cnt++;
    end
    chk(cnt, 0, "idle after mode back to direct");
    $display("test auto done");
  endtask

  // ********************************
  // run control
  // ********************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // whole run is a few hundred cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    scan_trigger = 1'b0;
    conv_done = 1'b0;
    alarms = 9'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_clear();
    test_direct();
    test_auto();
    end_sim();
  end
endmodule
`default_nettype wire
